// >>> hw/apc_defs.vh
// register map, field positions, reset values, clock rate and wake times in ns for the converter control
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// ==========================================
// register addresses
`define APC_A_READOUT   8'h00
`define APC_A_SWING     8'h01
`define APC_A_PERF      8'h03
`define APC_A_OFSEN     8'h3d
`define APC_A_DMODE     8'h42
`define APC_A_PWR       8'h45
`define APC_A_HF_B      8'h4a
`define APC_A_HF_A      8'h58
`define APC_A_HF_C      8'h66
`define APC_A_HF_D      8'h74
`define APC_A_PED_B     8'hbf
`define APC_A_PED_A     8'hc1
`define APC_A_PED_C     8'hc3
`define APC_A_PED_D     8'hc5
`define APC_A_LOOP      8'hcf
`define APC_A_SWEN      8'hf1

// ==========================================
// writable bit masks, all other bits read zero
`define APC_M_READOUT   8'h01
`define APC_M_SWING     8'hfc
`define APC_M_PERF      8'h03
`define APC_M_OFSEN     8'h20
`define APC_M_DMODE     8'h08
`define APC_M_PWR       8'he5
`define APC_M_HF        8'h01
`define APC_M_PED       8'he0
`define APC_M_LOOP      8'hbc
`define APC_M_SWEN      8'h03

// ==========================================
// field positions
`define APC_B_READOUT   0
`define APC_B_SWRST     1
`define APC_B_PINFN     0
`define APC_B_GPD       2
`define APC_B_DSTR      5
`define APC_B_CSTR      6
`define APC_B_STBY      7
`define APC_B_OFSEN     5
`define APC_B_DM1       3
`define APC_B_FRZ       7
`define APC_B_HF        0
`define APC_PED_HI      7
`define APC_PED_LO      5
`define APC_TC_HI       5
`define APC_TC_LO       2
`define APC_SWG_HI      7
`define APC_SWG_LO      2

// ==========================================
// values and timing
`define APC_RST_VAL     8'h00
`define APC_SWEN_ON     2'h3
`define APC_CLK_MHZ     40
`define APC_GPD_WAKE_NS 100000
`define APC_STB_WAKE_NS 10000

`endif

// >>> hw/apc_spi.v
// serial configuration slave: 8-bit address then 8-bit data, msb first
`timescale 1ns/1ps
module apc_spi (
    input  wire       clk,
    input  wire       rst,
    input  wire       sen_n,
    input  wire       sclk,
    input  wire       sdata,
    input  wire [7:0] rd_q,
    output reg        wr_stb,
    output reg  [7:0] wr_addr,
    output reg  [7:0] wr_data,
    output reg  [7:0] rd_addr,
    output wire       sdo
);
    reg        sclk_d;
    reg [4:0]  cnt;
    reg [14:0] sh;
    reg [7:0]  osh;
    wire       rise = sclk & ~sclk_d;
    wire       fall = ~sclk & sclk_d;

    assign sdo = osh[7];

    always @(posedge clk) begin
        sclk_d <= sclk;
        wr_stb <= 1'b0;
        if (rst) begin
            cnt     <= 5'h00;
            sh      <= 15'h0000;
            osh     <= 8'h00;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            rd_addr <= 8'h00;
        end else if (sen_n) begin
            cnt <= 5'h00;
            osh <= 8'h00;
        end else begin
            if (rise && cnt != 5'h10) begin
                sh  <= {sh[13:0], sdata};
                cnt <= cnt + 5'h01;
                if (cnt == 5'h07)
                    rd_addr <= {sh[6:0], sdata};
                if (cnt == 5'h0f) begin
                    wr_stb  <= 1'b1;
                    wr_addr <= sh[14:7];
                    wr_data <= {sh[6:0], sdata};
                end
            end
            // readback bits change on the falling edge, host samples on rising
            if (fall && cnt == 5'h08)
                osh <= rd_q;
            else if (fall && cnt > 5'h08)
                osh <= {osh[6:0], 1'b0};
        end
    end
endmodule

// >>> hw/apc_ofs.v
// one channel of the digital offset correction loop
`timescale 1ns/1ps
module apc_ofs #(
    parameter DW = 11
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          en,
    input  wire          hold,
    input  wire          vld,
    input  wire [3:0]    tc,
    input  wire [2:0]    ped,
    input  wire [DW-1:0] din,
    output reg  [DW-1:0] dout
);
    localparam XW = DW + 2;
    localparam AW = XW + 16;

    reg  signed [AW-1:0] acc_r;
    wire signed [XW-1:0] est   = acc_r[AW-1:16];
    wire signed [XW-1:0] raw_x = {2'b00, din};
    wire signed [XW-1:0] cor   = raw_x - est;
    wire signed [XW-1:0] mid   = {3'b001, {(DW-1){1'b0}}};
    wire signed [XW-1:0] tgt   = mid + {{(XW-3){ped[2]}}, ped};
    wire signed [XW-1:0] err   = cor - tgt;
    // time constant is 2^tc cycles; the fraction keeps small errors alive
    wire signed [AW-1:0] step  = $signed({err, 16'h0000}) >>> tc;
    wire [DW-1:0]        dmax  = {DW{1'b1}};

    always @(posedge clk) begin
        if (rst || !en) begin
            acc_r <= {AW{1'b0}};
        end else if (vld && !hold) begin
            acc_r <= acc_r + step;
        end
        if (rst || !vld)
            dout <= {DW{1'b0}};
        else if (!en)
            dout <= din;
        else if (cor < 0)
            dout <= {DW{1'b0}};
        else if (cor > $signed({2'b00, dmax}))
            dout <= dmax;
        else
            dout <= cor[DW-1:0];
    end
endmodule

// >>> hw/apc_top.v
// converter configuration: register bank, power control, offset correction
// Functional notes
// - power-down pin acts standby or global by bit
// - global bit powers down channels, references, buffers
// - data buffer strength doubles when bit set
// - clock buffer strength doubles when bit set
// - standby bit parks all channels, fast wake
// - loop converges output to mid-code plus pedestal
// - pedestal is 3-bit signed in top bits
// - four separately addressed pedestal registers
// - freeze holds last estimate as correction
// - four-bit field sets loop time constant
// - two-bit performance field, 01/10 not for use
// - per-channel high-frequency bit in bit 0
// - swing control active only for code 11
// - offset enable needs digital mode bit one
// - readback pin driven only while readout set
`timescale 1ns/1ps
`include "apc_defs.vh"
module apc_top #(
    parameter DW = 11
) (
    input  wire          REF_CLK,
    input  wire          RESET,
    input  wire          SEN_N,
    input  wire          SCLK,
    input  wire          SDATA,
    output wire          SERIAL_READBACK_PIN,
    output wire          SERIAL_READBACK_OE,
    input  wire          PDN,
    input  wire [DW-1:0] ADC_A,
    input  wire [DW-1:0] ADC_B,
    input  wire [DW-1:0] ADC_C,
    input  wire [DW-1:0] ADC_D,
    output wire [DW-1:0] OUT_A,
    output wire [DW-1:0] OUT_B,
    output wire [DW-1:0] OUT_C,
    output wire [DW-1:0] OUT_D,
    output reg           OUT_VALID,
    output reg           CHAN_STANDBY,
    output reg           CHAN_PWR_DOWN,
    output reg           REF_PWR_DOWN,
    output reg           OBUF_PWR_DOWN,
    output reg           DATA_DRIVE_DBL,
    output reg           CLKOUT_DRIVE_DBL,
    output reg  [1:0]    PERF_TUNING,
    output reg           PERF_CODE_BAD,
    output reg  [3:0]    HIGH_FREQ,
    output reg           SWING_EN,
    output reg  [5:0]    SWING_SET
);

    // ==========================================
    // timing counts
    localparam integer GPD_CYC =
        `APC_GPD_WAKE_NS * `APC_CLK_MHZ / 1000;
    localparam integer STB_CYC =
        `APC_STB_WAKE_NS * `APC_CLK_MHZ / 1000;
    localparam [11:0] GPD_CNT = GPD_CYC[11:0];
    localparam [11:0] STB_CNT = STB_CYC[11:0];

    // ==========================================
    // register storage
    reg [7:0]  readout_r;
    reg [7:0]  swing_r;
    reg [7:0]  perf_r;
    reg [7:0]  ofsen_r;
    reg [7:0]  dmode_r;
    reg [7:0]  pwr_r;
    reg [7:0]  loop_r;
    reg [7:0]  swen_r;
    reg [7:0]  hf_a_r;
    reg [7:0]  hf_b_r;
    reg [7:0]  hf_c_r;
    reg [7:0]  hf_d_r;
    reg [7:0]  ped_a_r;
    reg [7:0]  ped_b_r;
    reg [7:0]  ped_c_r;
    reg [7:0]  ped_d_r;
    reg        swrst_r;

    // ==========================================
    // serial port wiring
    wire       wr_stb;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] rd_addr;
    wire       sdo;
    reg  [7:0] rd_q;
    wire       wr_ok;
    wire       rdbk_on;

    // ==========================================
    // power and loop state
    reg  [11:0] wake_r;
    reg  [11:0] wake_nxt;
    wire        stby_eff;
    wire        gpd_eff;
    wire        live;
    wire        loop_en;
    wire        loop_hold;
    wire [3:0]  tc;
    wire [11:0] ped_w;
    wire [4*DW-1:0] din_w;
    wire [4*DW-1:0] dout_w;

    function [7:0] wmask;
        input [7:0] d;
        input [7:0] m;
        begin
            wmask = d & m;
        end
    endfunction

    function [2:0] ped_of;
        input [7:0] r;
        begin
            ped_of = r[`APC_PED_HI:`APC_PED_LO];
        end
    endfunction

    // only the full 11 code opens swing control; 01 and 10 stay off
    function swing_on;
        input [7:0] r;
        begin
            swing_on = (r[1:0] == `APC_SWEN_ON);
        end
    endfunction

    function hf_of;
        input [7:0] r;
        begin
            hf_of = r[`APC_B_HF];
        end
    endfunction

    // ==========================================
    // serial slave
    apc_spi u_spi (
        .clk     (REF_CLK),
        .rst     (RESET),
        .sen_n   (SEN_N),
        .sclk    (SCLK),
        .sdata   (SDATA),
        .rd_q    (rd_q),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .sdo     (sdo)
    );

    // pin is released whenever readout is off
    assign rdbk_on             = readout_r[`APC_B_READOUT];
    assign SERIAL_READBACK_OE  = rdbk_on;
    assign SERIAL_READBACK_PIN = rdbk_on & sdo;

    // readout address stays writable so readout can be turned off again
    assign wr_ok = wr_stb &
        (~rdbk_on | (wr_addr == `APC_A_READOUT));

    // ==========================================
    // register writes
    always @(posedge REF_CLK) begin
        swrst_r <= 1'b0;
        if (RESET || swrst_r) begin
            readout_r <= `APC_RST_VAL;
            swing_r   <= `APC_RST_VAL;
            perf_r    <= `APC_RST_VAL;
            ofsen_r   <= `APC_RST_VAL;
            dmode_r   <= `APC_RST_VAL;
            pwr_r     <= `APC_RST_VAL;
            loop_r    <= `APC_RST_VAL;
            swen_r    <= `APC_RST_VAL;
            hf_a_r    <= `APC_RST_VAL;
            hf_b_r    <= `APC_RST_VAL;
            hf_c_r    <= `APC_RST_VAL;
            hf_d_r    <= `APC_RST_VAL;
            ped_a_r   <= `APC_RST_VAL;
            ped_b_r   <= `APC_RST_VAL;
            ped_c_r   <= `APC_RST_VAL;
            ped_d_r   <= `APC_RST_VAL;
        end else if (wr_ok) begin
            // masks keep unlisted bits at zero
            case (wr_addr)
                `APC_A_READOUT: begin
                    readout_r <= wmask(wr_data, `APC_M_READOUT);
                    swrst_r   <= wr_data[`APC_B_SWRST];
                end
                `APC_A_SWING:
                    swing_r <= wmask(wr_data, `APC_M_SWING);
                `APC_A_PERF:
                    perf_r  <= wmask(wr_data, `APC_M_PERF);
                `APC_A_OFSEN:
                    ofsen_r <= wmask(wr_data, `APC_M_OFSEN);
                `APC_A_DMODE:
                    dmode_r <= wmask(wr_data, `APC_M_DMODE);
                `APC_A_PWR:
                    pwr_r   <= wmask(wr_data, `APC_M_PWR);
                `APC_A_LOOP:
                    loop_r  <= wmask(wr_data, `APC_M_LOOP);
                `APC_A_SWEN:
                    swen_r  <= wmask(wr_data, `APC_M_SWEN);
                `APC_A_HF_A:
                    hf_a_r  <= wmask(wr_data, `APC_M_HF);
                `APC_A_HF_B:
                    hf_b_r  <= wmask(wr_data, `APC_M_HF);
                `APC_A_HF_C:
                    hf_c_r  <= wmask(wr_data, `APC_M_HF);
                `APC_A_HF_D:
                    hf_d_r  <= wmask(wr_data, `APC_M_HF);
                `APC_A_PED_A:
                    ped_a_r <= wmask(wr_data, `APC_M_PED);
                `APC_A_PED_B:
                    ped_b_r <= wmask(wr_data, `APC_M_PED);
                `APC_A_PED_C:
                    ped_c_r <= wmask(wr_data, `APC_M_PED);
                `APC_A_PED_D:
                    ped_d_r <= wmask(wr_data, `APC_M_PED);
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // register readback
    always @* begin
        case (rd_addr)
            `APC_A_READOUT: rd_q = readout_r;
            `APC_A_SWING:   rd_q = swing_r;
            `APC_A_PERF:    rd_q = perf_r;
            `APC_A_OFSEN:   rd_q = ofsen_r;
            `APC_A_DMODE:   rd_q = dmode_r;
            `APC_A_PWR:     rd_q = pwr_r;
            `APC_A_LOOP:    rd_q = loop_r;
            `APC_A_SWEN:    rd_q = swen_r;
            `APC_A_HF_A:    rd_q = hf_a_r;
            `APC_A_HF_B:    rd_q = hf_b_r;
            `APC_A_HF_C:    rd_q = hf_c_r;
            `APC_A_HF_D:    rd_q = hf_d_r;
            `APC_A_PED_A:   rd_q = ped_a_r;
            `APC_A_PED_B:   rd_q = ped_b_r;
            `APC_A_PED_C:   rd_q = ped_c_r;
            `APC_A_PED_D:   rd_q = ped_d_r;
            default:        rd_q = 8'h00;
        endcase
    end

    // ==========================================
    // power control
    assign stby_eff = pwr_r[`APC_B_STBY] |
        (PDN & ~pwr_r[`APC_B_PINFN]);
    assign gpd_eff  = pwr_r[`APC_B_GPD] |
        (PDN & pwr_r[`APC_B_PINFN]);

    // data is withheld during wake-up so the loop never learns from it
    always @* begin
        wake_nxt = wake_r;
        if (gpd_eff)
            wake_nxt = GPD_CNT;
        // standby never cuts short a longer wake still running
        else if (stby_eff && wake_r < STB_CNT)
            wake_nxt = STB_CNT;
        else if (!stby_eff && wake_r != 12'h000)
            wake_nxt = wake_r - 12'h001;
    end

    assign live = ~gpd_eff & ~stby_eff & (wake_r == 12'h000);

    always @(posedge REF_CLK) begin
        if (RESET) begin
            wake_r           <= 12'h000;
            OUT_VALID        <= 1'b0;
            CHAN_STANDBY     <= 1'b0;
            CHAN_PWR_DOWN    <= 1'b0;
            REF_PWR_DOWN     <= 1'b0;
            OBUF_PWR_DOWN    <= 1'b0;
            DATA_DRIVE_DBL   <= 1'b0;
            CLKOUT_DRIVE_DBL <= 1'b0;
            PERF_TUNING      <= 2'h0;
            PERF_CODE_BAD    <= 1'b0;
            HIGH_FREQ        <= 4'h0;
            SWING_EN         <= 1'b0;
            SWING_SET        <= 6'h00;
        end else begin
            wake_r           <= wake_nxt;
            OUT_VALID        <= live;
            CHAN_STANDBY     <= stby_eff & ~gpd_eff;
            CHAN_PWR_DOWN    <= gpd_eff;
            REF_PWR_DOWN     <= gpd_eff;
            OBUF_PWR_DOWN    <= gpd_eff;
            DATA_DRIVE_DBL   <= pwr_r[`APC_B_DSTR];
            CLKOUT_DRIVE_DBL <= pwr_r[`APC_B_CSTR];
            PERF_TUNING      <= perf_r[1:0];
            // forbidden codes are flagged, not blocked
            PERF_CODE_BAD    <= perf_r[0] ^ perf_r[1];
            HIGH_FREQ        <= {hf_of(hf_d_r), hf_of(hf_c_r),
                                 hf_of(hf_b_r), hf_of(hf_a_r)};
            SWING_EN         <= swing_on(swen_r);
            SWING_SET        <= swing_on(swen_r) ?
                                swing_r[`APC_SWG_HI:`APC_SWG_LO] : 6'h00;
        end
    end

    // ==========================================
    // offset correction loops
    assign loop_en   = ofsen_r[`APC_B_OFSEN] & dmode_r[`APC_B_DM1];
    assign loop_hold = loop_r[`APC_B_FRZ];
    assign tc        = loop_r[`APC_TC_HI:`APC_TC_LO];
    assign ped_w     = {ped_of(ped_d_r), ped_of(ped_c_r),
                        ped_of(ped_b_r), ped_of(ped_a_r)};
    assign din_w     = {ADC_D, ADC_C, ADC_B, ADC_A};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            apc_ofs #(
                .DW (DW)
            ) u_ofs (
                .clk  (REF_CLK),
                .rst  (RESET),
                .en   (loop_en),
                .hold (loop_hold),
                .vld  (live),
                .tc   (tc),
                .ped  (ped_w[3*g +: 3]),
                .din  (din_w[DW*g +: DW]),
                .dout (dout_w[DW*g +: DW])
            );
        end
    endgenerate

    assign OUT_A = dout_w[DW*0 +: DW];
    assign OUT_B = dout_w[DW*1 +: DW];
    assign OUT_C = dout_w[DW*2 +: DW];
    assign OUT_D = dout_w[DW*3 +: DW];

endmodule

// >>> testbench/apc_chk.sv
// property checker on the converter control top ports
`timescale 1ns/1ps
module apc_chk #(
    parameter DW = 11
) (
    input wire          REF_CLK,
    input wire          RESET,
    input wire          PDN,
    input wire          SERIAL_READBACK_PIN,
    input wire          SERIAL_READBACK_OE,
    input wire [DW-1:0] OUT_A,
    input wire [DW-1:0] OUT_B,
    input wire [DW-1:0] OUT_C,
    input wire [DW-1:0] OUT_D,
    input wire          OUT_VALID,
    input wire          CHAN_STANDBY,
    input wire          CHAN_PWR_DOWN,
    input wire          REF_PWR_DOWN,
    input wire          OBUF_PWR_DOWN,
    input wire [1:0]    PERF_TUNING,
    input wire          PERF_CODE_BAD,
    input wire          SWING_EN,
    input wire [5:0]    SWING_SET
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // ==========================================
    // power state, readback, idle data, tuning flag and swing gating
    sdo_quiet_a: assert property (!SERIAL_READBACK_OE |-> !SERIAL_READBACK_PIN)
        else $error("readback pin active while readout off");
    gpd_all_a: assert property (CHAN_PWR_DOWN == REF_PWR_DOWN &&
        REF_PWR_DOWN == OBUF_PWR_DOWN)
        else $error("global power-down outputs disagree");
    gpd_excl_a: assert property (CHAN_PWR_DOWN |-> !CHAN_STANDBY)
        else $error("standby shown during global power-down");
    down_inval_a: assert property (CHAN_PWR_DOWN || CHAN_STANDBY |-> !OUT_VALID)
        else $error("data valid while powered down");
    pin_fn_a: assert property ($rose(PDN) |-> ##[1:2] (CHAN_STANDBY || CHAN_PWR_DOWN))
        else $error("power-down pin had no effect");
    gpd_wake_a: assert property ($fell(CHAN_PWR_DOWN) |-> !OUT_VALID [*8])
        else $error("data valid right after global wake");
    stby_wake_a: assert property ($fell(CHAN_STANDBY) && !CHAN_PWR_DOWN |->
        !OUT_VALID [*8])
        else $error("data valid right after standby wake");
    out_idle_a: assert property (!OUT_VALID |-> (OUT_A | OUT_B | OUT_C | OUT_D) == 0)
        else $error("data nonzero while not valid");
    perf_flag_a: assert property (PERF_CODE_BAD ==
        (PERF_TUNING == 2'h1 || PERF_TUNING == 2'h2))
        else $error("reserved tuning code flag wrong");
    swing_off_a: assert property (!SWING_EN |-> SWING_SET == 6'h00)
        else $error("swing setting leaks while disabled");
    cover property ($rose(OUT_VALID));
    cover property ($rose(CHAN_STANDBY));
    cover property ($rose(CHAN_PWR_DOWN));
    cover property ($rose(SWING_EN));
endmodule

// >>> testbench/apc_host.sv
// serial configuration host model driving the converter control
`timescale 1ns/1ps
module apc_host (
    input  wire        clk,
    input  wire        sdo,
    output logic       sen_n,
    output logic       sclk,
    output logic       sdata,
    output logic       rd_done,
    output logic [7:0] rd_data
);
    // idle levels follow the pin pulls: enable up, clock and data down
    initial begin
        sen_n = 1'b1;
        sclk = 1'b0;
        sdata = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
    end
    // ==========================================
    // one frame, each clock level held two cycles since the slave oversamples
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
        logic [15:0] w;
        w = {a, d};
        @(negedge clk) sen_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk) sdata = w[i];
            @(negedge clk) begin
                if (i < 8) rd_data[i] = sdo;
                sclk = 1'b1;
            end
            @(negedge clk);
            @(negedge clk) sclk = 1'b0;
        end
        @(negedge clk) begin
            sen_n = 1'b1;
            sdata = 1'b0;
            rd_done = rd;
        end
        @(negedge clk) rd_done = 1'b0;
        @(negedge clk);
    endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module testbench;
    localparam DW = 11;
    typedef struct { int sel; logic [31:0] e; string n; } note_t;
    note_t        q[$];
    logic         REF_CLK = 1'b0;
    logic         RESET = 1'b1;
    logic         PDN = 1'b0;
    logic         smp = 1'b0;
    logic [DW-1:0] ADC_A = 11'h400, ADC_B = 11'h400, ADC_C = 11'h400, ADC_D = 11'h400;
    wire          SEN_N, SCLK, SDATA, SERIAL_READBACK_PIN, SERIAL_READBACK_OE, hst_done;
    wire [7:0]    hst_q;
    wire [DW-1:0] OUT_A, OUT_B, OUT_C, OUT_D;
    wire          OUT_VALID, CHAN_STANDBY, CHAN_PWR_DOWN, REF_PWR_DOWN, OBUF_PWR_DOWN;
    wire          DATA_DRIVE_DBL, CLKOUT_DRIVE_DBL, PERF_CODE_BAD, SWING_EN;
    wire [1:0]    PERF_TUNING;
    wire [3:0]    HIGH_FREQ;
    wire [5:0]    SWING_SET;
    wire          sdo_w = SERIAL_READBACK_OE ? SERIAL_READBACK_PIN : ~SERIAL_READBACK_PIN;
    wire [31:0]   st_obs = {11'h0, PERF_CODE_BAD, PERF_TUNING, HIGH_FREQ, SWING_EN, SWING_SET,
                  CLKOUT_DRIVE_DBL, DATA_DRIVE_DBL, OBUF_PWR_DOWN, REF_PWR_DOWN, CHAN_PWR_DOWN,
                  CHAN_STANDBY, OUT_VALID};
    int           mismatches = 0, comparisons = 0, cyc = 0, seed, k;
    logic [7:0]   m03 = 0, m45 = 0, m01 = 0, mf1 = 0, v;
    logic [3:0]   mhf = 0;
    logic [7:0]   ex [11];
    logic [7:0]   ra [11] = '{8'h03, 8'h45, 8'h4a, 8'h58, 8'h66, 8'h74, 8'hbf, 8'hc1, 8'hc3,
                              8'hc5, 8'hcf};
    logic [7:0]   rm [11] = '{8'h03, 8'he5, 8'h01, 8'h01, 8'h01, 8'h01, 8'he0, 8'he0, 8'he0,
                              8'he0, 8'hbc};
    logic [7:0]   pw [5] = '{8'h00, 8'h01, 8'h80, 8'h04, 8'h60};
    logic [4:0]   pp = 5'b00011;

    always #12.5 REF_CLK = ~REF_CLK;

    apc_top #(.DW(DW)) i_dut (.REF_CLK(REF_CLK), .RESET(RESET), .SEN_N(SEN_N), .SCLK(SCLK),
        .SDATA(SDATA), .SERIAL_READBACK_PIN(SERIAL_READBACK_PIN),
        .SERIAL_READBACK_OE(SERIAL_READBACK_OE), .PDN(PDN), .ADC_A(ADC_A),
        .ADC_B(ADC_B), .ADC_C(ADC_C), .ADC_D(ADC_D), .OUT_A(OUT_A), .OUT_B(OUT_B),
        .OUT_C(OUT_C), .OUT_D(OUT_D), .OUT_VALID(OUT_VALID), .CHAN_STANDBY(CHAN_STANDBY),
        .CHAN_PWR_DOWN(CHAN_PWR_DOWN), .REF_PWR_DOWN(REF_PWR_DOWN),
        .OBUF_PWR_DOWN(OBUF_PWR_DOWN), .DATA_DRIVE_DBL(DATA_DRIVE_DBL),
        .CLKOUT_DRIVE_DBL(CLKOUT_DRIVE_DBL), .PERF_TUNING(PERF_TUNING),
        .PERF_CODE_BAD(PERF_CODE_BAD), .HIGH_FREQ(HIGH_FREQ), .SWING_EN(SWING_EN),
        .SWING_SET(SWING_SET));
    apc_host i_host (.clk(REF_CLK), .sdo(sdo_w), .sen_n(SEN_N), .sclk(SCLK), .sdata(SDATA),
        .rd_done(hst_done), .rd_data(hst_q));

    // ==========================================
    // expected status word from the bench's own register copy
    function automatic logic [31:0] st_exp(input logic vld);
        logic g, s, w;
        g = m45[2] | (PDN & m45[0]);
        s = (m45[7] | (PDN & ~m45[0])) & ~g;
        w = (mf1[1:0] == 2'h3);
        return {11'h0, m03[1:0] == 2'h1 || m03[1:0] == 2'h2, m03[1:0], mhf, w,
                w ? m01[7:2] : 6'h00, m45[6], m45[5], g, g, g, s, vld};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back('{0, {24'h0, e}, "readback"});
        i_host.xfer(a, 8'h00, 1'b1);
    endtask
    task automatic look(input int s, input logic [31:0] e, input int w);
        repeat (w) @(negedge REF_CLK);
        q.push_back('{s, e, s == 1 ? "status" : "data out"});
        smp = 1'b1;
        @(negedge REF_CLK) smp = 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // monitor: oldest note against what the outputs show, plus hang guard
    always @(posedge REF_CLK) begin : mon
        note_t t;
        logic [31:0] g;
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            results();
        end else if ((smp || hst_done) && q.size() > 0) begin
            t = q.pop_front();
            case (t.sel)
                0: g = {24'h0, hst_q};
                1: g = st_obs;
                2: g = {21'h0, OUT_A};
                3: g = {21'h0, OUT_B};
                4: g = {21'h0, OUT_C};
                default: g = {21'h0, OUT_D};
            endcase
            `CHK(t.n, t.e, g)
        end
    end

    initial begin
        seed = 32'h2116;
        repeat (8) @(negedge REF_CLK);
        RESET = 1'b0;
        wr(8'h00, 8'h01);
        for (k = 0; k < 11; k++) rd(ra[k], 8'h00);
        rd(8'h02, 8'h00);
        $display("test reset values done");
        wr(8'h00, 8'h00);
        for (k = 0; k < 11; k++) begin
            v = $random(seed);
            ex[k] = v & rm[k];
            wr(ra[k], v);
        end
        m03 = ex[0];
        m45 = ex[1];
        mhf = {ex[5][0], ex[4][0], ex[2][0], ex[3][0]};
        look(1, st_exp(~(m45[2] | m45[7])), 4100);
        wr(8'h00, 8'h01);
        for (k = 0; k < 11; k++) rd(ra[k], ex[k]);
        wr(8'h45, ~ex[1]);
        rd(8'h45, ex[1]);
        wr(8'h00, 8'h00);
        $display("test register access done");
        for (k = 0; k < 5; k++) begin
            m45 = pw[k];
            wr(8'h45, m45);
            PDN = pp[k];
            look(1, st_exp(1'b0), 4);
        end
        // host must not expect valid data during the slow global wake
        look(1, st_exp(1'b0), 3890);
        look(1, st_exp(1'b1), 200);
        m45 = 8'h80;
        wr(8'h45, m45);
        m45 = 8'h00;
        wr(8'h45, m45);
        look(1, st_exp(1'b0), 2);
        look(1, st_exp(1'b1), 4100);
        $display("test power control done");
        m01 = $random(seed);
        wr(8'h01, m01);
        for (k = 0; k < 4; k++) begin
            mf1 = k[7:0];
            wr(8'hf1, mf1);
            look(1, st_exp(1'b1), 4);
            m03 = k[7:0];
            wr(8'h03, m03);
            look(1, st_exp(1'b1), 4);
        end
        $display("test swing and tuning done");
        ADC_A = 11'h3ec + 11'($random(seed) & 63);
        ADC_B = 11'h3ec + 11'($random(seed) & 63);
        ADC_C = 11'h3ec + 11'($random(seed) & 63);
        ADC_D = 11'h3ec + 11'($random(seed) & 63);
        wr(8'hc1, 8'h60);
        wr(8'hbf, 8'h80);
        wr(8'hc3, 8'h00);
        wr(8'hc5, 8'he0);
        wr(8'hcf, 8'h10);
        wr(8'h42, 8'h08);
        wr(8'h3d, 8'h20);
        look(2, 32'h403, 3000);
        look(3, 32'h3fc, 1);
        look(4, 32'h400, 1);
        look(5, 32'h3ff, 1);
        wr(8'hcf, 8'h90);
        ADC_A = ADC_A + 11'h005;
        look(2, 32'h408, 300);
        wr(8'hcf, 8'h10);
        look(2, 32'h403, 2000);
        wr(8'h42, 8'h00);
        look(2, {21'h0, ADC_A}, 10);
        wr(8'h00, 8'h02);
        wr(8'h00, 8'h01);
        rd(8'hc1, 8'h00);
        $display("test offset loop done");
        results();
    end
endmodule

bind apc_top apc_chk #(.DW(DW)) i_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PDN(PDN),
    .SERIAL_READBACK_PIN(SERIAL_READBACK_PIN), .SERIAL_READBACK_OE(SERIAL_READBACK_OE),
    .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_C(OUT_C),
    .OUT_D(OUT_D), .OUT_VALID(OUT_VALID), .CHAN_STANDBY(CHAN_STANDBY),
    .CHAN_PWR_DOWN(CHAN_PWR_DOWN), .REF_PWR_DOWN(REF_PWR_DOWN), .OBUF_PWR_DOWN(OBUF_PWR_DOWN),
    .PERF_TUNING(PERF_TUNING), .PERF_CODE_BAD(PERF_CODE_BAD), .SWING_EN(SWING_EN),
    .SWING_SET(SWING_SET));
